/* edc_pkg.sv */
/*
 * edc_pkg: constants for the host-side controller of the 16-bit SEC/DED
 * error detection and correction part.
 * Assumes one 20 MHz clock and a part that is fully combinational.
 */
// Functional notes
// R1 - both selects low: write, checkword out
// R2 - latch low, drive high: read inputs in
// R3 - both high: latch word, flags valid
// R4 - latch high, drive low: corrected data out
// R5 - check bits 0..2 parity over data
// R6 - check bits 3..5 parity over data
// R7 - syndrome bit low where check disagrees
// R8 - no error: both flags low
// R9 - one error: single flag, corrected
// R10 - two errors: both flags, no correction
// R11 - data lines bidirectional, mode selects driver
// R12 - check lines bidirectional, mode selects driver
// R13 - two dedicated flag outputs from check
// R14 - inputs stable around latch select edge
// R15 - drive select enables device drivers
// R16 - fixed parity sense, clean word all-high
package edc_pkg;
	localparam int DATA_W = 16;
	localparam int CHK_W  = 6;
	localparam int ADDR_W = 3;

	// register word offsets (byte address = 4 * index)
	localparam logic [ADDR_W-1:0] REG_CTRL   = 3'h0;
	localparam logic [ADDR_W-1:0] REG_WDATA  = 3'h1;
	localparam logic [ADDR_W-1:0] REG_WCHECK = 3'h2;
	localparam logic [ADDR_W-1:0] REG_RDATA  = 3'h3;
	localparam logic [ADDR_W-1:0] REG_RCHECK = 3'h4;
	localparam logic [ADDR_W-1:0] REG_STATUS = 3'h5;
	localparam logic [ADDR_W-1:0] REG_IRQ    = 3'h6;
	localparam logic [ADDR_W-1:0] REG_MASK   = 3'h7;

	// control register fields
	localparam int CTRL_OP_LSB = 0; // 2-bit operation code
	localparam int CTRL_GO_BIT = 2; // write 1 to start
	localparam logic [1:0] OP_WRITE   = 2'h0; // generate checkword
	localparam logic [1:0] OP_CORRECT = 2'h1; // read, latch, correct
	// status fields
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_SEF_BIT  = 1;
	localparam int ST_DEF_BIT  = 2;
	// irq status / mask fields
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_SEF_BIT  = 1;
	localparam int IRQ_DEF_BIT  = 2;
	localparam logic [2:0] MASK_RST = 3'h0;

	// timing: each phase time in ns, then cycles at 20 MHz (rounded up)
	localparam int CLK_NS        = 50;
	localparam int SETTLE_NS     = 100; // data/check settle before latch edge
	localparam int HOLD_NS       = 50;  // hold after latch edge
	localparam int PROP_NS       = 50;  // flags and outputs valid
	localparam int SETTLE_CYC    = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC      = (HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int PROP_CYC      = (PROP_NS + CLK_NS - 1) / CLK_NS;
	localparam int SYNC_CYC      = 2;   // pin synchroniser latency in cycles
	localparam int CNT_W         = 4;

	typedef enum logic [2:0] {
		EDC_IDLE, EDC_WR_SET, EDC_WR_CAP, EDC_RD_SET, EDC_RD_LATCH,
		EDC_RD_FLAG, EDC_RD_CORR, EDC_DONE
	} edc_state_t;
endpackage : edc_pkg

/* edc_sync.sv */
/*
 * edc_sync: two-flop synchroniser bank for pins read back from the part.
 * Assumes inputs are asynchronous to clk_i; output is the second flop only.
 */
`timescale 1ns/1ps
module edc_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_ni,
	// raw and synchronised data
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta_q;

	// first flop feeds only the second
	always_ff @(posedge clk_i or negedge rst_ni) begin
		if (!rst_ni) begin
			meta_q <= '0;
			q_o    <= '0;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end
endmodule : edc_sync

/* edc_ctrl.sv */
/*
 * edc_ctrl: host controller for the 16-bit SEC/DED correction part.
 * Software orders a write (checkword generation) or a read-and-correct
 * cycle over Avalon-MM; the controller sequences both select pins and the
 * two bidirectional buses. Assumes the part is combinational and settles
 * within PROP_NS, and that the memory side is modelled by software data.
 */
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module edc_ctrl
	import edc_pkg::*;
(
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              resetn_i,
	// avalon-mm slave
	input  wire logic [ADDR_W-1:0] avs_address_i,
	input  wire logic              avs_read_i,
	input  wire logic              avs_write_i,
	input  wire logic [31:0]       avs_writedata_i,
	output logic      [31:0]       avs_readdata_o,
	output logic                   avs_waitrequest_o,
	// mode selects to the part
	output logic                   output_drive_select_o,
	output logic                   latch_correct_select_o,
	// data lines, split three ways
	input  wire logic [DATA_W-1:0] data_lines_i,
	output logic      [DATA_W-1:0] data_lines_o,
	output logic                   data_lines_oe_o,
	// check lines, split three ways
	input  wire logic [CHK_W-1:0]  check_lines_i,
	output logic      [CHK_W-1:0]  check_lines_o,
	output logic                   check_lines_oe_o,
	// error flags from the part
	input  wire logic              single_error_flag_i,
	input  wire logic              double_error_flag_i,
	// interrupt
	output logic                   irq_o
);
	logic [1:0]        rst_sync_q;
	logic              rst_n;
	logic [DATA_W-1:0] data_s;
	logic [CHK_W-1:0]  chk_s;
	logic [1:0]        flag_s;

	// reset release through two flops, assert asynchronously
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) rst_sync_q <= 2'h0;
		else           rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	// pins from the part pass two flops before any use
	edc_sync #(.WIDTH(DATA_W + CHK_W + 2)) u_sync (
		.clk_i  (clk_i),
		.rst_ni (rst_n),
		.d_i    ({data_lines_i, check_lines_i, single_error_flag_i, double_error_flag_i}),
		.q_o    ({data_s, chk_s, flag_s})
	);

	edc_state_t        st_q, st_d;
	logic [CNT_W-1:0]  cnt_q, cnt_d;
	logic [1:0]        op_q, op_d;
	logic [DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
	logic [CHK_W-1:0]  wchk_q, wchk_d, rchk_q, rchk_d;
	logic              sef_q, sef_d, def_q, def_d;
	logic [2:0]        irq_q, irq_d, mask_q, mask_d;
	logic              s0_q, s0_d, s1_q, s1_d;
	logic              doe_q, doe_d, coe_q, coe_d;
	logic [31:0]       rd_q, rd_d;
	logic              wait_q, wait_d;
	logic              acc;
	logic [2:0]        ev;

	assign acc = avs_read_i | avs_write_i;

	// register decode for reads
	function automatic logic [31:0] rd_mux(input logic [ADDR_W-1:0] a);
		case (a)
			REG_CTRL:   rd_mux = {30'h0, op_q};
			REG_WDATA:  rd_mux = {16'h0, wdata_q};
			REG_WCHECK: rd_mux = {26'h0, wchk_q};
			REG_RDATA:  rd_mux = {16'h0, rdata_q};
			REG_RCHECK: rd_mux = {26'h0, rchk_q};
			REG_STATUS: rd_mux = {29'h0, def_q, sef_q, (st_q != EDC_IDLE)};
			REG_IRQ:    rd_mux = {29'h0, irq_q};
			REG_MASK:   rd_mux = {29'h0, mask_q};
			default:    rd_mux = 32'h0;
		endcase
	endfunction : rd_mux

	// sequencer, bus slave and interrupt next-state logic
	always_comb begin
		st_d = st_q; cnt_d = cnt_q; op_d = op_q;
		wdata_d = wdata_q; wchk_d = wchk_q; rdata_d = rdata_q; rchk_d = rchk_q;
		sef_d = sef_q; def_d = def_q; mask_d = mask_q;
		s0_d = s0_q; s1_d = s1_q; doe_d = doe_q; coe_d = coe_q;
		rd_d = rd_q; wait_d = 1'b1; ev = 3'h0;
		// bus: one idle wait cycle, answer on the second
		if (acc && wait_q) begin
			wait_d = 1'b0;
			rd_d = rd_mux(avs_address_i);
		end
		// a write lands only on the edge where waitrequest is low
		if (avs_write_i && !wait_q) begin
			case (avs_address_i)
				REG_CTRL: begin
					if (avs_writedata_i[CTRL_GO_BIT] && st_q == EDC_IDLE) begin
						op_d  = avs_writedata_i[CTRL_OP_LSB +: 2];
						st_d  = (op_d == OP_WRITE) ? EDC_WR_SET : EDC_RD_SET;
						cnt_d = CNT_W'(SETTLE_CYC);
					end
				end
				REG_WDATA:  wdata_d = avs_writedata_i[DATA_W-1:0];
				REG_WCHECK: wchk_d  = avs_writedata_i[CHK_W-1:0];
				REG_MASK:   mask_d  = avs_writedata_i[2:0];
				default: ;
			endcase
		end
		if (cnt_q != '0) cnt_d = cnt_q - 1'b1;
		case (st_q)
			EDC_IDLE: begin
				s0_d = 1'b1; s1_d = 1'b0; doe_d = 1'b0; coe_d = 1'b0; // part idles in read
			end
			EDC_WR_SET: begin
				s1_d = 1'b0; s0_d = 1'b0; // R1
				doe_d = 1'b1; coe_d = 1'b0; // R11 R12
				if (cnt_q == '0) begin
					st_d = EDC_WR_CAP;
					cnt_d = CNT_W'(PROP_CYC);
				end
			end
			EDC_WR_CAP: if (cnt_q == '0) begin
				wchk_d = chk_s; // generated checkword per R5 R6
				sef_d = flag_s[1]; def_d = flag_s[0]; // R1 expects both low
				st_d = EDC_DONE;
			end
			EDC_RD_SET: begin
				s1_d = 1'b0; s0_d = 1'b1; // R2
				doe_d = 1'b1; coe_d = 1'b1; // R11 R12
				if (cnt_q == '0) begin
					st_d = EDC_RD_LATCH;
					cnt_d = CNT_W'(HOLD_CYC);
				end
			end
			EDC_RD_LATCH: begin
				s1_d = 1'b1; // R3 R14 - latch edge, inputs still driven
				if (cnt_q == '0) begin
					doe_d = 1'b0; coe_d = 1'b0; // release before part drives, R15
					st_d = EDC_RD_FLAG;
					cnt_d = CNT_W'(PROP_CYC);
				end
			end
			EDC_RD_FLAG: if (cnt_q == '0) begin
				s0_d = 1'b0; // R4 - part drives corrected data and syndrome
				st_d = EDC_RD_CORR;
				// new pin levels need the synchroniser latency on top
				cnt_d = CNT_W'(PROP_CYC + SYNC_CYC);
			end
			EDC_RD_CORR: if (cnt_q == '0) begin
				rdata_d = data_s; rchk_d = chk_s; // R7 syndrome, all-high clean R16
				sef_d = flag_s[1]; def_d = flag_s[0]; // R8 R9 R10 R13
				ev[IRQ_SEF_BIT] = flag_s[1] & ~flag_s[0];
				ev[IRQ_DEF_BIT] = flag_s[0]; // R10 double error interrupt
				st_d = EDC_DONE;
			end
			EDC_DONE: begin
				s0_d = 1'b1; s1_d = 1'b0;
				ev[IRQ_DONE_BIT] = 1'b1;
				st_d = EDC_IDLE;
			end
			default: st_d = EDC_IDLE;
		endcase
		// sticky status: set wins over write-one-to-clear
		irq_d = irq_q;
		if (avs_write_i && !wait_q && avs_address_i == REG_IRQ)
			irq_d = irq_q & ~avs_writedata_i[2:0];
		irq_d = irq_d | ev;
	end

	// register all state
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= EDC_IDLE; cnt_q <= '0; op_q <= OP_WRITE;
			wdata_q <= '0; wchk_q <= '0; rdata_q <= '0; rchk_q <= '0;
			sef_q <= 1'b0; def_q <= 1'b0; irq_q <= 3'h0; mask_q <= MASK_RST;
			s0_q <= 1'b1; s1_q <= 1'b0; doe_q <= 1'b0; coe_q <= 1'b0;
			rd_q <= 32'h0; wait_q <= 1'b1;
		end else begin
			st_q <= st_d; cnt_q <= cnt_d; op_q <= op_d;
			wdata_q <= wdata_d; wchk_q <= wchk_d; rdata_q <= rdata_d; rchk_q <= rchk_d;
			sef_q <= sef_d; def_q <= def_d; irq_q <= irq_d; mask_q <= mask_d;
			s0_q <= s0_d; s1_q <= s1_d; doe_q <= doe_d; coe_q <= coe_d;
			rd_q <= rd_d; wait_q <= wait_d;
		end
	end

	// interrupt output registered for a clean level
	logic irq_out_q;
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) irq_out_q <= 1'b0;
		else        irq_out_q <= |(irq_d & mask_d);
	end

	assign avs_readdata_o         = rd_q;
	assign avs_waitrequest_o      = wait_q;
	assign output_drive_select_o  = s0_q;
	assign latch_correct_select_o = s1_q;
	assign data_lines_o           = wdata_q; // R11
	assign data_lines_oe_o        = doe_q;
	assign check_lines_o          = wchk_q; // R12
	assign check_lines_oe_o       = coe_q;
	assign irq_o                  = irq_out_q;
endmodule : edc_ctrl

/* edc_ctrl_asserts.sv */
/* edc_ctrl_asserts: pin and bus handshake checks on edc_ctrl.
   Assumes the bind below and the single clk_i domain. */
`timescale 1ns/1ps
module edc_ctrl_asserts (
	// clock, reset and bus handshake
	input wire logic        clk_i,
	input wire logic        resetn_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic        avs_waitrequest_o,
	// pins toward the part
	input wire logic        output_drive_select_o,
	input wire logic        latch_correct_select_o,
	input wire logic [15:0] data_lines_o,
	input wire logic        data_lines_oe_o,
	input wire logic        check_lines_oe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// contention: the part owns the buses in correct mode
	bus_free_a: assert property (
		latch_correct_select_o && !output_drive_select_o |->
		!data_lines_oe_o && !check_lines_oe_o)
		else $error("host drives a bus the part owns");
	// part drives the checkword in write mode
	chk_free_a: assert property (
		!latch_correct_select_o && !output_drive_select_o |-> !check_lines_oe_o)
		else $error("host drives check lines in write mode");
	// latch edge only in read mode, both buses driven, data lines steady
	latch_hold_a: assert property (
		$rose(latch_correct_select_o) |-> output_drive_select_o && data_lines_oe_o
		&& check_lines_oe_o && $stable(data_lines_o))
		else $error("latch edge without steady driven buses");
	// one wait cycle, then a one-cycle answer
	wait_ans_a: assert property (
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("bus request not answered next cycle");
	wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("answer held longer than one cycle");
	wait_cause_a: assert property (
		$fell(avs_waitrequest_o) |-> $past(avs_read_i) || $past(avs_write_i))
		else $error("answer without a request");
endmodule : edc_ctrl_asserts

bind edc_ctrl edc_ctrl_asserts i_chk (.clk_i(clk_i), .resetn_i(resetn_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
	.output_drive_select_o(output_drive_select_o), .data_lines_o(data_lines_o),
	.latch_correct_select_o(latch_correct_select_o), .data_lines_oe_o(data_lines_oe_o),
	.check_lines_oe_o(check_lines_oe_o));

/* edc_part.sv */
/* edc_part: behavioural model of the correction part with bus resolution.
   Assumes host pins as inputs; returns the resolved bus levels. */
`timescale 1ns/1ps
module edc_part (
	// clock for the float pattern, mode selects
	input  wire logic        clk_i,
	input  wire logic        drv_i,
	input  wire logic        lat_i,
	// host side of the buses
	input  wire logic [15:0] hd_i,
	input  wire logic        hd_oe_i,
	input  wire logic [5:0]  hc_i,
	input  wire logic        hc_oe_i,
	// resolved buses and flags
	output logic      [15:0] dl_o,
	output logic      [5:0]  cl_o,
	output logic             flag_se_o,
	output logic             flag_de_o
);
	localparam logic [15:0] M [6] = '{16'h271B, 16'h496D, 16'h92B6, 16'h1CC7, 16'hE0F8, 16'hFF00};
	logic [15:0] ld, cd;
	logic [5:0]  lc, w, e;
	logic        flt = 1'h0;
	// undriven bus toggles so stale data never looks valid
	always @(posedge clk_i) flt <= ~flt;
	// capture on the rising latch select
	always @(posedge lat_i) begin
		ld <= dl_o;
		lc <= cl_o;
	end
	// even parity per bit; a clean word gives an all-high syndrome
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			w[i] = ^(hd_i & M[i]);
			e[i] = ^(ld & M[i]) ^ lc[i];
		end
		cd = ld;
		for (int i = 0; i < 16; i++) begin
			if (e == {M[5][i], M[4][i], M[3][i], M[2][i], M[1][i], M[0][i]})
				cd[i] = ~ld[i];
		end
	end
	// part drives data when correcting, check in write and correct
	always_comb begin
		dl_o = hd_oe_i ? hd_i : {16{flt}};
		cl_o = hc_oe_i ? hc_i : {6{flt}};
		if (lat_i && !drv_i) begin
			dl_o = cd;
			cl_o = ~e;
		end else if (!lat_i && !drv_i) begin
			cl_o = w;
		end
	end
	// flags only while latched; odd weight means one error
	assign flag_se_o = lat_i && (e != 6'h00);
	assign flag_de_o = lat_i && (e != 6'h00) && !(^e);
endmodule : edc_part

/* tb_edc_ctrl.sv */
/* tb_edc_ctrl: self-checking bench for edc_ctrl with the part model.
   Assumes edc_pkg offsets and a one-wait-cycle Avalon answer. */
`timescale 1ns/1ps
module tb_edc_ctrl;
	import edc_pkg::*;
	localparam logic [15:0] M [6] = '{16'h271B, 16'h496D, 16'h92B6, 16'h1CC7, 16'hE0F8, 16'hFF00};
	logic        clk_i = 1'h0, resetn_i = 1'h0, rd = 1'h0, wr = 1'h0;
	logic [2:0]  adr = 3'h0;
	logic [31:0] wd = 32'h0, rdata;
	logic        wreq, drv, lat, hdoe, hcoe, fse, fde, irq;
	logic [15:0] hd, dl;
	logic [5:0]  hc, cl;
	int          errors = 0, n_checks = 0;
	always #25 clk_i = ~clk_i;
	// design and part
	edc_ctrl i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
		.output_drive_select_o(drv), .latch_correct_select_o(lat), .data_lines_i(dl),
		.data_lines_o(hd), .data_lines_oe_o(hdoe), .check_lines_i(cl), .check_lines_o(hc),
		.check_lines_oe_o(hcoe), .single_error_flag_i(fse), .double_error_flag_i(fde),
		.irq_o(irq));
	edc_part i_part (.clk_i(clk_i), .drv_i(drv), .lat_i(lat), .hd_i(hd), .hd_oe_i(hdoe),
		.hc_i(hc), .hc_oe_i(hcoe), .dl_o(dl), .cl_o(cl), .flag_se_o(fse), .flag_de_o(fde));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// request held until waitrequest is seen low
	task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		adr <= a;
		wr <= w;
		rd <= ~w;
		wd <= d;
		do @(posedge clk_i); while (wreq !== 1'h0);
		q = rdata;
		rd <= 1'h0;
		wr <= 1'h0;
	endtask : bus
	function automatic logic [5:0] gen(input logic [15:0] d);
		for (int i = 0; i < 6; i++)
			gen[i] = ^(d & M[i]);
	endfunction : gen
	task automatic run(input logic [1:0] op, input logic [15:0] d, input logic [5:0] c);
		logic [31:0] q;
		bus(1'h1, REG_WDATA, {16'h0, d}, q);
		bus(1'h1, REG_WCHECK, {26'h0, c}, q);
		bus(1'h1, REG_CTRL, {29'h0, 1'h1, op}, q);
		q = 32'h1;
		for (int i = 0; i < 50 && q[ST_BUSY_BIT] !== 1'h0; i++)
			bus(1'h0, REG_STATUS, 32'h0, q);
		check({31'h0, q[ST_BUSY_BIT]}, 32'h0);
	endtask : run
	task automatic sc_write();
		logic [31:0] q;
		logic [15:0] v [4] = '{16'h0000, 16'h8000, 16'h0001, 16'hA5C3};
		foreach (v[k]) begin
			run(OP_WRITE, v[k], 6'h00);
			bus(1'h0, REG_WCHECK, 32'h0, q);
			check(q, {26'h0, gen(v[k])});
			bus(1'h0, REG_STATUS, 32'h0, q);
			check(q, 32'h0);
		end
	endtask : sc_write
	// every single error, none, and three kinds of double error
	task automatic sc_read();
		logic [31:0] q;
		logic [15:0] df;
		logic [5:0]  cf, e;
		logic        dbl;
		logic [15:0] dt [4] = '{16'h0000, 16'h8001, 16'h0400, 16'h0000};
		logic [5:0]  ct [4] = '{6'h00, 6'h00, 6'h20, 6'h05};
		for (int k = 0; k < 26; k++) begin
			df = (k < 16) ? 16'h1 << k : (k > 21 ? dt[k-22] : 16'h0);
			cf = (k > 15 && k < 22) ? 6'h1 << (k - 16) : (k > 21 ? ct[k-22] : 6'h0);
			e = gen(df) ^ cf;
			dbl = (e != 6'h0) && !(^e);
			run(OP_CORRECT, 16'h3C5A ^ df, gen(16'h3C5A) ^ cf);
			bus(1'h0, REG_RDATA, 32'h0, q);
			check(q, {16'h0, dbl ? 16'h3C5A ^ df : 16'h3C5A});
			bus(1'h0, REG_RCHECK, 32'h0, q);
			check(q, {26'h0, ~e});
			bus(1'h0, REG_STATUS, 32'h0, q);
			check(q, {29'h0, dbl, e != 6'h0, 1'h0});
		end
	endtask : sc_read
	task automatic sc_irq();
		logic [31:0] q;
		bus(1'h0, REG_MASK, 32'h0, q);
		check(q, 32'h0);
		bus(1'h1, REG_MASK, 32'h4, q);
		for (int m = 0; m < 2; m++) begin
			bus(1'h1, REG_IRQ, 32'h7, q);
			run(OP_CORRECT, 16'h0000, 6'h03);
			bus(1'h0, REG_IRQ, 32'h0, q);
			check(q, 32'h5);
			check({31'h0, irq}, {31'h0, m == 0});
			bus(1'h1, REG_MASK, 32'h2, q);
		end
		bus(1'h1, REG_IRQ, 32'h7, q);
		bus(1'h0, REG_IRQ, 32'h0, q);
		check(q, 32'h0);
	endtask : sc_irq
	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run
	// reset, scenarios, verdict
	initial begin
		repeat (3) @(posedge clk_i);
		resetn_i <= 1'h1;
		repeat (3) @(posedge clk_i);
		sc_write();
		sc_read();
		sc_irq();
		complete_run();
	end
	// watchdog: far beyond the roughly one thousand cycles needed
	initial begin
		#1000000;
		errors++;
		complete_run();
	end
endmodule : tb_edc_ctrl
